// [hw/umf_defs.svh]
// Offsets, field positions, reset values and counts of the serial port block
// Assumes byte addresses on an AHB-Lite bus, one 32-bit word per register
`ifndef UMF_DEFS_SVH
`define UMF_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define UMF_OFF_DATA 8'h00
`define UMF_OFF_FLOW 8'h04
`define UMF_OFF_CTRL 8'h08
`define UMF_OFF_CKSEL 8'h0C
`define UMF_OFF_THR 8'h10
`define UMF_OFF_DIV 8'h14
`define UMF_OFF_STAT 8'h18

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define UMF_CTRL_ARTS 0
`define UMF_CTRL_ACTS 1
`define UMF_CTRL_ADSR 2
`define UMF_CTRL_ADTR 3
`define UMF_CTRL_RTS_ON 4
`define UMF_CTRL_DTR_ON 5
`define UMF_CTRL_W 6

// ----------------------------------------------------------------
// Clock select register fields
// ----------------------------------------------------------------
`define UMF_CKS_RXSRC_LSB 0
`define UMF_CKS_RX_EXT 2'b01
`define UMF_CKS_TXEXT 6

// ----------------------------------------------------------------
// Threshold register fields, five bits each
// ----------------------------------------------------------------
`define UMF_THR_UP_LSB 0
`define UMF_THR_LO_LSB 8
`define UMF_THR_DTR_LSB 16

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define UMF_ST_TXBUSY 8
`define UMF_ST_HOLDFULL 9
`define UMF_ST_FLOWPEND 10
`define UMF_ST_HALTED 11
`define UMF_ST_CTS 12
`define UMF_ST_DSR 13
`define UMF_ST_RI 14
`define UMF_ST_DCD 15
`define UMF_ST_OVERRUN 16

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define UMF_CTRL_RST 6'h00
`define UMF_CKSEL_RST 8'h00
`define UMF_THR_RST 32'h000E_040C
`define UMF_DIV_RST 16'h0056
`define UMF_FRAME_BITS 4'hA
`define UMF_RX_BITS 3'h7
`define UMF_RXF_FULL 5'h10
`define UMF_HSIZE_WORD 3'b010

`endif

// [hw/umf_pkg.sv]
// Types and shared decode helpers of the serial port block
// Assumes the constants header is included by the users of these types
`default_nettype none
package umf_pkg;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } umf_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_DATA = 3'b010,
    RX_STOP = 3'b100
  } umf_rx_state_t;

  // Five-bit field taken out of a register word
  function automatic logic [4:0] umf_field5(input logic [31:0] w, input int unsigned lsb);
    return w[lsb +: 5];
  endfunction

endpackage
`default_nettype wire

// [hw/umf_sync.sv]
// Two-stage synchroniser for the modem, data and clock pins
// Assumes idle-high reset value suits every pin it carries
`timescale 1ns/1ns
`default_nettype none
module umf_sync #(
  parameter int unsigned W = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {W{1'b1}};
      q <= {W{1'b1}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// [hw/umf_tx.sv]
// Character transmitter, 8 data bits, one start and one stop bit
// Assumes a one-cycle bit tick from the selected transmit clock source
`timescale 1ns/1ns
`default_nettype none
`include "umf_defs.svh"
module umf_tx import umf_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic data_valid,
  input wire logic [7:0] data,
  input wire logic flow_valid,
  input wire logic [7:0] flow_data,
  input wire logic hold,
  output wire logic data_take,
  output wire logic flow_take,
  output wire logic txd,
  output wire logic busy
);
  umf_tx_state_t state;
  logic [9:0] sh;
  logic [3:0] cnt;

  wire idle = (state == TX_IDLE);
  // Flow characters ignore the hold; data waits for it to clear
  assign flow_take = idle & tick & flow_valid;
  assign data_take = idle & tick & ~flow_valid & data_valid & ~hold;
  wire last = (state == TX_SEND) & tick & (cnt == 4'h1);
  wire [7:0] load = flow_take ? flow_data : data;
  assign txd = sh[0];
  assign busy = (state == TX_SEND);

  // ----------------------------------------------------------------
  // Shifter; a started character always runs to its stop bit
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TX_IDLE;
      sh <= 10'h3FF;
      cnt <= 4'h0;
    end else if (flow_take | data_take) begin
      state <= TX_SEND;
      sh <= {1'b1, load, 1'b0};
      cnt <= `UMF_FRAME_BITS;
    end else if (last) begin
      state <= TX_IDLE;
      sh <= 10'h3FF;
      cnt <= 4'h0;
    end else if (busy && tick) begin
      sh <= {1'b1, sh[9:1]};
      cnt <= cnt - 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_flow_load;
    idle && tick && flow_valid;
  endsequence

  sequence s_any_load;
    flow_take || data_take;
  endsequence

  AST_FLOW_PRIO: assert property (@(posedge clk) disable iff (!rst_n)
    s_flow_load |=> busy && sh[8:1] == $past(flow_data) && !txd)
    else $error("flow character not sent first");

  AST_FINISH_CHAR: assert property (@(posedge clk) disable iff (!rst_n)
    (busy && !last) |=> busy)
    else $error("character cut short");

  AST_HOLD_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    (idle && hold && !flow_valid) |=> idle)
    else $error("transmitter left idle while held");

  AST_FRAME_LEN: assert property (@(posedge clk) disable iff (!rst_n)
    s_any_load |=> (cnt == `UMF_FRAME_BITS) && busy)
    else $error("frame length wrong");
endmodule
`default_nettype wire

// [hw/umf_top.sv]
// Serial port channel with modem flow control and clock source selection
// Assumes an AHB-Lite master and modem pins synchronous to hclk
// Contract
// - With auto request-to-send, drop it at upper level, raise below lower level.
// - With auto clear-to-send, a deasserted input lets the character finish, then idles.
// - A held transmitter sends only flow characters until clear-to-send returns, then resumes.
// - With auto data-set-ready, deassertion finishes the character and sends only flow characters until return.
// - In-band flow characters go out whatever the modem inputs say.
// - Receive clock comes from external receive pin when source field is 01.
// - Clock select bit 6 makes the transmitter, and receiver indirectly, use external clock.
// - With auto terminal-ready, the output follows the receive level against its threshold.
`timescale 1ns/1ns
`default_nettype none
`include "umf_defs.svh"
module umf_top import umf_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic rxd,
  output wire logic txd,
  output logic rts_n,
  output logic dtr_n,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  input wire logic rx_clk_in,
  input wire logic tx_clk_in
);
  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [`UMF_CTRL_W-1:0] ctrl;
  logic [7:0] clock_select_register;
  logic [31:0] thr;
  logic [15:0] div;
  logic wr_q, rd_q;
  logic [7:0] addr_q;
  logic hold_valid, flow_valid, overrun;
  logic [7:0] hold_data, flow_data;
  logic [7:0] rxf [16];
  logic [3:0] wptr, rptr;
  logic [4:0] level;
  logic [15:0] baud_cnt;
  logic baud_tick;
  logic rxclk_prev, txclk_prev;
  umf_rx_state_t rx_state;
  logic [7:0] rx_sh;
  logic [2:0] rx_cnt;
  logic [6:0] pins_s;

  // ----------------------------------------------------------------
  // Synchronised pins
  // ----------------------------------------------------------------
  umf_sync #(.W(7)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d({tx_clk_in, rx_clk_in, rxd, dcd_n, ri_n, dsr_n, cts_n}),
    .q(pins_s)
  );

  wire cts_ok = ~pins_s[0];
  wire dsr_ok = ~pins_s[1];
  wire ring = ~pins_s[2];
  wire dcd_ok = ~pins_s[3];
  wire rxd_s = pins_s[4];
  wire ext_rx_edge = pins_s[5] & ~rxclk_prev;
  wire ext_tx_edge = pins_s[6] & ~txclk_prev;

  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  wire tx_ext = clock_select_register[`UMF_CKS_TXEXT];
  wire [1:0] rx_src = clock_select_register[`UMF_CKS_RXSRC_LSB +: 2];
  wire tx_tick = tx_ext ? ext_tx_edge : baud_tick;
  // Receiver follows the transmit clock source unless its own pin is chosen
  wire rx_tick = (rx_src == `UMF_CKS_RX_EXT) ? ext_rx_edge :
                 (tx_ext ? ext_tx_edge : baud_tick);

  // ----------------------------------------------------------------
  // Flow control decisions
  // ----------------------------------------------------------------
  wire [4:0] thr_up = umf_field5(thr, `UMF_THR_UP_LSB);
  wire [4:0] thr_lo = umf_field5(thr, `UMF_THR_LO_LSB);
  wire [4:0] thr_dtr = umf_field5(thr, `UMF_THR_DTR_LSB);
  wire cts_hold = ctrl[`UMF_CTRL_ACTS] & ~cts_ok;
  wire dsr_hold = ctrl[`UMF_CTRL_ADSR] & ~dsr_ok;
  wire tx_hold = cts_hold | dsr_hold;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire take = hsel & htrans[1] & hready;
  wire take_wr = take & hwrite & (hsize == `UMF_HSIZE_WORD);
  wire take_rd = take & ~hwrite;
  wire wr_data = wr_q & (addr_q == `UMF_OFF_DATA);
  wire wr_flow = wr_q & (addr_q == `UMF_OFF_FLOW);
  wire wr_ctrl = wr_q & (addr_q == `UMF_OFF_CTRL);
  wire wr_cks = wr_q & (addr_q == `UMF_OFF_CKSEL);
  wire wr_thr = wr_q & (addr_q == `UMF_OFF_THR);
  wire wr_div = wr_q & (addr_q == `UMF_OFF_DIV);
  wire wr_stat = wr_q & (addr_q == `UMF_OFF_STAT);
  wire pop = rd_q & (addr_q == `UMF_OFF_DATA) & (level != 5'h00);

  wire data_take, flow_take, tx_busy;
  wire rx_full = (level == `UMF_RXF_FULL);
  wire rx_push = (rx_state == RX_STOP) & rx_tick & rxd_s;

  wire [31:0] stat_word = {15'h0000, overrun, dcd_ok, ring, dsr_ok, cts_ok,
                           tx_hold, flow_valid, hold_valid, tx_busy, 3'h0, level};
  wire [31:0] rd_value =
    (addr_q == `UMF_OFF_DATA) ? {24'h00_0000, (level != 5'h00) ? rxf[rptr] : 8'h00} :
    (addr_q == `UMF_OFF_FLOW) ? {24'h00_0000, flow_data} :
    (addr_q == `UMF_OFF_CTRL) ? {26'h000_0000, ctrl} :
    (addr_q == `UMF_OFF_CKSEL) ? {24'h00_0000, clock_select_register} :
    (addr_q == `UMF_OFF_THR) ? thr :
    (addr_q == `UMF_OFF_DIV) ? {16'h0000, div} :
    (addr_q == `UMF_OFF_STAT) ? stat_word : 32'h0000_0000;

  // ----------------------------------------------------------------
  // AHB-Lite slave: writes take no wait, reads take one
  // ----------------------------------------------------------------
  // The read wait lets a write in its data phase land before the read samples
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      wr_q <= take_wr;
      rd_q <= take_rd;
      if (take) addr_q <= haddr;
      hreadyout <= ~take_rd;
      if (rd_q) hrdata <= rd_value;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `UMF_CTRL_RST;
      clock_select_register <= `UMF_CKSEL_RST;
      thr <= `UMF_THR_RST;
      div <= `UMF_DIV_RST;
    end else begin
      if (wr_ctrl) ctrl <= hwdata[`UMF_CTRL_W-1:0];
      if (wr_cks) clock_select_register <= {1'b0, hwdata[6:0]};
      if (wr_thr) thr <= hwdata & 32'h001F_1F1F;
      if (wr_div) div <= hwdata[15:0];
    end
  end

  // Writes to a full holding slot are dropped; status shows the slot state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_valid <= 1'b0;
      hold_data <= 8'h00;
      flow_valid <= 1'b0;
      flow_data <= 8'h00;
    end else begin
      if (wr_data && !hold_valid) begin
        hold_valid <= 1'b1;
        hold_data <= hwdata[7:0];
      end else if (data_take) hold_valid <= 1'b0;
      if (wr_flow && !flow_valid) begin
        flow_valid <= 1'b1;
        flow_data <= hwdata[7:0];
      end else if (flow_take) flow_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bit rate and external clock edges
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_cnt <= 16'h0000;
      baud_tick <= 1'b0;
      rxclk_prev <= 1'b1;
      txclk_prev <= 1'b1;
    end else begin
      baud_tick <= (baud_cnt == 16'h0000);
      baud_cnt <= (baud_cnt == 16'h0000) ? div : baud_cnt - 16'h0001;
      rxclk_prev <= pins_s[5];
      txclk_prev <= pins_s[6];
    end
  end

  // ----------------------------------------------------------------
  // Receiver, one sample per bit tick
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state <= RX_IDLE;
      rx_sh <= 8'h00;
      rx_cnt <= 3'h0;
    end else if (rx_tick) begin
      unique case (rx_state)
        RX_IDLE: begin
          if (!rxd_s) rx_state <= RX_DATA;
          rx_cnt <= 3'h0;
        end
        RX_DATA: begin
          rx_sh <= {rxd_s, rx_sh[7:1]};
          rx_cnt <= rx_cnt + 3'h1;
          if (rx_cnt == `UMF_RX_BITS) rx_state <= RX_STOP;
        end
        RX_STOP: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Receive store; a byte arriving when full is lost and flagged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wptr <= 4'h0;
      rptr <= 4'h0;
      level <= 5'h00;
      overrun <= 1'b0;
    end else begin
      if (rx_push && !rx_full) wptr <= wptr + 4'h1;
      if (pop) rptr <= rptr + 4'h1;
      level <= level + {4'h0, rx_push & ~rx_full} - {4'h0, pop};
      // New overrun wins over a clear in the same cycle
      if (rx_push && rx_full) overrun <= 1'b1;
      else if (wr_stat && hwdata[`UMF_ST_OVERRUN]) overrun <= 1'b0;
    end
  end

  always_ff @(posedge hclk) begin
    if (rx_push && !rx_full) rxf[wptr] <= rx_sh;
  end

  // ----------------------------------------------------------------
  // Modem outputs
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
    end else begin
      if (!ctrl[`UMF_CTRL_ARTS]) rts_n <= ~ctrl[`UMF_CTRL_RTS_ON];
      else if (level >= thr_up) rts_n <= 1'b1;
      else if (level < thr_lo) rts_n <= 1'b0;
      if (!ctrl[`UMF_CTRL_ADTR]) dtr_n <= ~ctrl[`UMF_CTRL_DTR_ON];
      else dtr_n <= (level >= thr_dtr);
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  umf_tx u_tx (
    .clk(hclk),
    .rst_n(hresetn),
    .tick(tx_tick),
    .data_valid(hold_valid),
    .data(hold_data),
    .flow_valid(flow_valid),
    .flow_data(flow_data),
    .hold(tx_hold),
    .data_take(data_take),
    .flow_take(flow_take),
    .txd(txd),
    .busy(tx_busy)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_read_taken;
    take_rd;
  endsequence

  sequence s_read_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  AST_READ_WAIT: assert property (s_read_taken |=> s_read_answer)
    else $error("read answer timing wrong");

  AST_RTS_OFF: assert property (ctrl[`UMF_CTRL_ARTS] && level >= thr_up |=> rts_n)
    else $error("request-to-send not dropped at upper level");

  AST_RTS_ON: assert property (
    ctrl[`UMF_CTRL_ARTS] && level < thr_lo && level < thr_up |=> !rts_n)
    else $error("request-to-send not raised below lower level");

  AST_DTR_FOLLOW: assert property (
    ctrl[`UMF_CTRL_ADTR] |=> dtr_n == ($past(level) >= $past(thr_dtr)))
    else $error("terminal-ready does not follow level");

  AST_CTS_HOLD: assert property (ctrl[`UMF_CTRL_ACTS] && !cts_ok |-> !data_take)
    else $error("data started while clear-to-send deasserted");

  AST_DSR_HOLD: assert property (ctrl[`UMF_CTRL_ADSR] && !dsr_ok |-> !data_take)
    else $error("data started while data-set-ready deasserted");

  // The receiver may only move on an edge of its own pin once that pin is chosen
  AST_RX_SRC: assert property (
    rx_src == `UMF_CKS_RX_EXT && !ext_rx_edge |=> $stable(rx_state) && $stable(rx_sh))
    else $error("receiver moved without an external receive clock edge");

  AST_TX_SRC: assert property (tx_ext && !ext_tx_edge |-> !data_take && !flow_take)
    else $error("transmitter started without an external transmit clock edge");

  // Synchroniser still shows its reset value for two edges after release
  AST_SYNC_DELAY: assert property (
    $past(hresetn, 2) |-> cts_ok == !$past(cts_n, 2))
    else $error("clear-to-send not two stages late");
endmodule
`default_nettype wire

// [verification/umf_modem.sv]
// Modem side of one channel: serial input line, status lines, external bit clocks
// Assumes it shares hclk with the channel and is steered through its tasks
`timescale 1ns/1ns
`default_nettype none
module umf_modem (
  input wire logic hclk,
  output var logic rxd,
  output var logic cts_n,
  output var logic dsr_n,
  output var logic ri_n,
  output var logic dcd_n,
  output var logic rx_clk_in,
  output var logic tx_clk_in
);
  logic tx_ck_on;
  logic [2:0] tx_div;

  initial begin
    rxd = 1'b1;
    cts_n = 1'b0;
    dsr_n = 1'b0;
    ri_n = 1'b1;
    dcd_n = 1'b1;
    rx_clk_in = 1'b0;
    tx_clk_in = 1'b0;
    tx_ck_on = 1'b0;
    tx_div = 3'h0;
  end

  // ----------------------------------------------------------------
  // Status lines, all active low
  // ----------------------------------------------------------------
  task automatic set_lines(input logic cts, input logic dsr, input logic ring);
    @(posedge hclk);
    cts_n <= cts;
    dsr_n <= dsr;
    ri_n <= ring;
  endtask

  task automatic set_txck(input logic on);
    @(posedge hclk);
    tx_ck_on <= on;
  endtask

  // Transmit clock at hclk/16, standing still while switched off
  always @(posedge hclk) begin
    if (tx_ck_on) begin
      tx_div <= tx_div + 3'h1;
      if (tx_div == 3'h7) begin
        tx_clk_in <= ~tx_clk_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // One 8N1 frame, LSB first; with ext set the receive clock rises mid-bit
  // ----------------------------------------------------------------
  task automatic send_byte(input logic [7:0] b, input logic ext, input int per);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge hclk);
      rxd <= fr[i];
      rx_clk_in <= 1'b0;
      repeat (per / 2 - 1) @(posedge hclk);
      @(posedge hclk);
      rx_clk_in <= ext;
      repeat (per - per / 2 - 1) @(posedge hclk);
    end
  endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench of one serial channel with modem flow control
// Assumes the channel top, its constants header and the modem model
`timescale 1ns/1ns
`default_nettype none
`include "umf_defs.svh"
module testbench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, txd, rts_n, dtr_n;
  logic rxd, cts_n, dsr_n, ri_n, dcd_n, rx_clk_in, tx_clk_in;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, d;
  wire logic hready;
  int err_count, tests_run;

  assign hready = hreadyout;

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  umf_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .rxd(rxd), .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n),
    .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n), .rx_clk_in(rx_clk_in),
    .tx_clk_in(tx_clk_in));

  umf_modem modem (.hclk(hclk), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
    .dcd_n(dcd_n), .rx_clk_in(rx_clk_in), .tx_clk_in(tx_clk_in));

  // ----------------------------------------------------------------
  // Compare, bus and line helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(a, 1'b1, v);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(a, 1'b0, 32'h0000_0000);
  endtask

  task automatic pin(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask

  // Waits for a start bit, then samples every bit in its middle
  task automatic get_frame(input int per, input logic [7:0] exp, input logic cut);
    logic [7:0] got;
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    if (cut) modem.set_lines(1'b1, 1'b1, 1'b1);
    repeat (per / 2 - (cut ? 1 : 0)) @(posedge hclk);
    pin("start bit", 1'b0, txd);
    for (int i = 0; i < 8; i++) begin
      repeat (per) @(posedge hclk);
      got[i] = txd;
    end
    repeat (per) @(posedge hclk);
    chk("character", {24'h0, exp}, {24'h0, got});
    pin("stop bit", 1'b1, txd);
  endtask

  task automatic quiet(input int n);
    logic low;
    low = 1'b0;
    repeat (n) begin
      @(posedge hclk);
      if (txd !== 1'b1) low = 1'b1;
    end
    pin("txd low while held", 1'b0, low);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    pin("txd", 1'b1, txd);
    pin("rts_n", 1'b1, rts_n);
    pin("dtr_n", 1'b1, dtr_n);
    rd(`UMF_OFF_THR);
    chk("thr", `UMF_THR_RST, d);
    rd(`UMF_OFF_DIV);
    chk("div", {16'h0, `UMF_DIV_RST}, d);
    rd(8'h1C);
    chk("unmapped", 32'h0, d);
    $display("test reset done");
  endtask

  task automatic t_cts;
    wr(`UMF_OFF_DIV, 32'h0000_0003);
    wr(`UMF_OFF_CTRL, 32'h0000_0002);
    wr(`UMF_OFF_DATA, 32'h0000_00A5);
    get_frame(4, 8'hA5, 1'b1);
    wr(`UMF_OFF_DATA, 32'h0000_003C);
    quiet(200);
    rd(`UMF_OFF_STAT);
    pin("held flag", 1'b1, d[`UMF_ST_HALTED]);
    wr(`UMF_OFF_FLOW, 32'h0000_0013);
    get_frame(4, 8'h13, 1'b0);
    quiet(100);
    rd(`UMF_OFF_FLOW);
    chk("flow char", 32'h13, d);
    modem.set_lines(1'b0, 1'b0, 1'b1);
    get_frame(4, 8'h3C, 1'b0);
    $display("test clear-to-send done");
  endtask

  task automatic t_dsr;
    wr(`UMF_OFF_CTRL, 32'h0000_0004);
    wr(`UMF_OFF_DATA, 32'h0000_007E);
    get_frame(4, 8'h7E, 1'b1);
    wr(`UMF_OFF_DATA, 32'h0000_0081);
    quiet(200);
    modem.set_lines(1'b0, 1'b0, 1'b1);
    get_frame(4, 8'h81, 1'b0);
    $display("test data-set-ready done");
  endtask

  task automatic t_levels;
    wr(`UMF_OFF_THR, 32'h0002_0103);
    wr(`UMF_OFF_CTRL, 32'h0000_0009);
    repeat (3) @(posedge hclk);
    pin("rts_n empty", 1'b0, rts_n);
    pin("dtr_n empty", 1'b0, dtr_n);
    modem.send_byte(8'h11, 1'b0, 4);
    modem.send_byte(8'h22, 1'b0, 4);
    repeat (8) @(posedge hclk);
    pin("rts_n level 2", 1'b0, rts_n);
    pin("dtr_n level 2", 1'b1, dtr_n);
    modem.send_byte(8'h33, 1'b0, 4);
    repeat (8) @(posedge hclk);
    pin("rts_n level 3", 1'b1, rts_n);
    rd(`UMF_OFF_DATA);
    chk("rx byte 1", 32'h11, d);
    pin("rts_n back to 2", 1'b1, rts_n);
    rd(`UMF_OFF_DATA);
    chk("rx byte 2", 32'h22, d);
    repeat (2) @(posedge hclk);
    pin("dtr_n level 1", 1'b0, dtr_n);
    pin("rts_n level 1", 1'b1, rts_n);
    rd(`UMF_OFF_DATA);
    chk("rx byte 3", 32'h33, d);
    repeat (2) @(posedge hclk);
    pin("rts_n level 0", 1'b0, rts_n);
    $display("test fifo levels done");
  endtask

  task automatic t_clocks;
    wr(`UMF_OFF_CTRL, 32'h0000_0000);
    wr(`UMF_OFF_CKSEL, 32'h0000_0001);
    modem.send_byte(8'hC3, 1'b1, 8);
    repeat (8) @(posedge hclk);
    rd(`UMF_OFF_DATA);
    chk("ext rx byte", 32'hC3, d);
    wr(`UMF_OFF_CKSEL, 32'h0000_0040);
    modem.set_txck(1'b1);
    wr(`UMF_OFF_DATA, 32'h0000_0096);
    get_frame(16, 8'h96, 1'b0);
    modem.send_byte(8'h5A, 1'b0, 16);
    repeat (40) @(posedge hclk);
    rd(`UMF_OFF_DATA);
    chk("indirect rx byte", 32'h5A, d);
    modem.set_txck(1'b0);
    $display("test clock sources done");
  endtask

  task automatic t_ring;
    modem.set_lines(1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge hclk);
    rd(`UMF_OFF_STAT);
    pin("ring", 1'b1, d[`UMF_ST_RI]);
    pin("no carrier", 1'b0, d[`UMF_ST_DCD]);
    modem.set_lines(1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge hclk);
    rd(`UMF_OFF_STAT);
    pin("no ring", 1'b0, d[`UMF_ST_RI]);
    wr(`UMF_OFF_CTRL, 32'h0000_0030);
    repeat (2) @(posedge hclk);
    pin("rts_n manual on", 1'b0, rts_n);
    pin("dtr_n manual on", 1'b0, dtr_n);
    $display("test ring done");
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // About 1500 cycles are expected; 30000 leaves ample margin
  initial begin
    repeat (30000) @(posedge hclk);
    err_count++;
    stop_test;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = `UMF_HSIZE_WORD;
    hwdata = 32'h0000_0000;
    err_count = 0;
    tests_run = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_cts;
    t_dsr;
    t_levels;
    t_clocks;
    t_ring;
    stop_test;
  end
endmodule
`default_nettype wire
